// file: pkg/spmd_pkg.sv
// constants and types for the segment prefix and byte move decode block
// assumes a 20-bit data space and a 16-bit offset inside the cpu core
package spmd_pkg;

  // ==========================================================
  // opcodes and address widths
  localparam logic [7:0] PREFIX_CODE = 8'h11;
  localparam logic [7:0] OP_LOAD_PTR3 = 8'h8b;
  localparam logic [7:0] OP_STORE_ABS_IMM = 8'hcf;
  localparam int ADDR_W = 20;
  localparam int OFS_W = 16;
  localparam int SEG_W = 4;
  // default window without a prefix: f0000h to fffffh
  localparam logic [SEG_W-1:0] WINDOW_SEG = 4'hf;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam int BYTE_W = 8;
  localparam int IDX_HI_LSB = 8;

  // ==========================================================
  // address forms handed over by the operand decoder
  typedef enum logic [2:0] {
    SPMD_AM_ABS16 = 3'h0,
    SPMD_AM_PTR2 = 3'h1,
    SPMD_AM_PTR3 = 3'h2,
    SPMD_AM_PTR2_DISP = 3'h3,
    SPMD_AM_PTR3_DISP = 3'h4,
    SPMD_AM_HI_IDX_WORD = 3'h5,
    SPMD_AM_LO_IDX_WORD = 3'h6,
    SPMD_AM_PAIR_WORD = 3'h7
  } spmd_amode_t;

  // ==========================================================
  // per-flag update code
  typedef enum logic [2:0] {
    SPMD_FL_KEEP = 3'h0,
    SPMD_FL_CLEAR = 3'h1,
    SPMD_FL_SET = 3'h2,
    SPMD_FL_RESULT = 3'h3,
    SPMD_FL_RESTORE = 3'h4
  } spmd_flcode_t;

  localparam int NUM_FLAGS = 3;
  localparam int FL_CY = 0;
  localparam int FL_AC = 1;
  localparam int FL_Z = 2;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 3'h0;
  localparam int FL_CODE_W = 3;

  // ==========================================================
  // prefix sequencer, gray along idle -> armed -> target and target -> armed; target -> idle flips both bits
  typedef enum logic [1:0] {
    SPMD_ST_IDLE = 2'h0,
    SPMD_ST_ARMED = 2'h1,
    SPMD_ST_TARGET = 2'h3
  } spmd_state_t;

endpackage : spmd_pkg

// file: rtl/spmd_flag_update.sv
// flag register of the program status word: zero, aux carry, carry
// assumes the update strobe and codes come from the same-clock decoder
`timescale 1ns/1ps
`default_nettype none

module spmd_flag_update (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic flag_wr,
  input wire logic [3*spmd_pkg::NUM_FLAGS-1:0] flag_code,
  input wire logic [spmd_pkg::NUM_FLAGS-1:0] result_flags,
  input wire logic [spmd_pkg::NUM_FLAGS-1:0] saved_flags,
  output logic [spmd_pkg::NUM_FLAGS-1:0] flags
);

  logic [spmd_pkg::NUM_FLAGS-1:0] next_flags;

  // ==========================================================
  // one flag under one code
  function automatic logic apply_code(input logic [2:0] code, input logic cur,
                                      input logic res, input logic sav);
    case (code)
      spmd_pkg::SPMD_FL_CLEAR: apply_code = 1'b0;
      spmd_pkg::SPMD_FL_SET: apply_code = 1'b1;
      spmd_pkg::SPMD_FL_RESULT: apply_code = res;
      spmd_pkg::SPMD_FL_RESTORE: apply_code = sav;
      default: apply_code = cur;
    endcase
  endfunction : apply_code

  // ==========================================================
  // next value per flag
  for (genvar g = 0; g < spmd_pkg::NUM_FLAGS; g++)
  begin : g_flag
    always_comb
    begin
      next_flags[g] = flags[g];
      if (flag_wr)
      begin
        next_flags[g] = apply_code(flag_code[spmd_pkg::FL_CODE_W*g +: spmd_pkg::FL_CODE_W],
                                   flags[g], result_flags[g], saved_flags[g]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      flags <= spmd_pkg::FLAGS_RESET;
    else
      flags <= next_flags;
  end

endmodule : spmd_flag_update

`default_nettype wire

// file: rtl/spmd_decode.sv
// segment prefix decode, data address generation, request hold-off, flags
// assumes all inputs come from cpu-core logic on ref_clk; no pin inputs
// assumes insn_done pulses only for instructions, never for a prefix byte
// assumes the next prefix byte may arrive in the same cycle as a target's insn_done
`timescale 1ns/1ps
`default_nettype none

module spmd_decode (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic insn_done,
  input wire logic addr_req,
  input wire logic [2:0] addr_mode,
  input wire logic [15:0] abs_offset,
  input wire logic [7:0] disp_byte,
  input wire logic [15:0] base_word,
  input wire logic [15:0] second_pointer_pair,
  input wire logic [15:0] third_pointer_pair,
  input wire logic [15:0] index_pair,
  input wire logic [3:0] extension_segment_reg,
  input wire logic irq_req,
  input wire logic dma_req,
  input wire logic flag_wr,
  input wire logic [8:0] flag_code,
  input wire logic [2:0] result_flags,
  input wire logic [2:0] saved_flags,
  output logic prefix_pending,
  output logic [19:0] data_addr,
  output logic data_addr_valid,
  output logic data_addr_ext,
  output logic irq_ack,
  output logic dma_ack,
  output logic [2:0] program_status_word
);

  spmd_pkg::spmd_state_t state;
  spmd_pkg::spmd_state_t next_state;
  logic next_prefix_pending;
  logic [19:0] next_data_addr;
  logic next_data_addr_valid;
  logic next_data_addr_ext;
  logic next_irq_ack;
  logic next_dma_ack;
  logic is_prefix;
  logic hold_off;

  // ==========================================================
  // prefix detection
  function automatic logic prefix_byte(input logic v, input logic [7:0] b);
    prefix_byte = v && (b == spmd_pkg::PREFIX_CODE);
  endfunction : prefix_byte

  assign is_prefix = prefix_byte(op_valid, op_byte);

  // ==========================================================
  // prefix sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      spmd_pkg::SPMD_ST_IDLE:
      begin
        if (is_prefix)
          next_state = spmd_pkg::SPMD_ST_ARMED;
      end
      spmd_pkg::SPMD_ST_ARMED:
      begin
        // a repeated prefix byte simply keeps the override armed
        // insn_done before the target byte belongs to no prefixed instruction
        if (op_valid && !is_prefix)
          next_state = spmd_pkg::SPMD_ST_TARGET;
        if (op_valid && !is_prefix && insn_done)
          next_state = spmd_pkg::SPMD_ST_IDLE;
      end
      spmd_pkg::SPMD_ST_TARGET:
      begin
        // back to back prefixes: the next prefix must not be lost at completion
        if (insn_done && is_prefix)
          next_state = spmd_pkg::SPMD_ST_ARMED;
        else if (insn_done)
          next_state = spmd_pkg::SPMD_ST_IDLE;
      end
      default: next_state = spmd_pkg::SPMD_ST_IDLE;
    endcase
    next_prefix_pending = (next_state != spmd_pkg::SPMD_ST_IDLE);
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= spmd_pkg::SPMD_ST_IDLE;
      prefix_pending <= 1'b0;
    end
    else
    begin
      state <= next_state;
      prefix_pending <= next_prefix_pending;
    end
  end

  // ==========================================================
  // data address generation
  // offsets wrap inside the selected 64 KB segment; carry never reaches the segment
  // so a pointer near ffffh folds back to 0000h of the same segment, not the next one
  // data_addr and its ext bit hold between requests; only the strobe pulses

  // unsigned byte added to a 16-bit value, wrapped
  function automatic logic [15:0] add_byte(input logic [15:0] a, input logic [7:0] b);
    add_byte = 16'(a + {8'h00, b});
  endfunction : add_byte

  function automatic logic [15:0] add_word(input logic [15:0] a, input logic [15:0] b);
    add_word = 16'(a + b);
  endfunction : add_word

  always_comb
  begin
    logic [15:0] ofs;
    logic [3:0] seg;
    ofs = abs_offset;
    seg = spmd_pkg::WINDOW_SEG;
    case (spmd_pkg::spmd_amode_t'(addr_mode))
      spmd_pkg::SPMD_AM_ABS16: ofs = abs_offset;
      spmd_pkg::SPMD_AM_PTR2: ofs = second_pointer_pair;
      spmd_pkg::SPMD_AM_PTR3: ofs = third_pointer_pair;
      spmd_pkg::SPMD_AM_PTR2_DISP:
        ofs = add_byte(second_pointer_pair, disp_byte);
      spmd_pkg::SPMD_AM_PTR3_DISP:
        ofs = add_byte(third_pointer_pair, disp_byte);
      spmd_pkg::SPMD_AM_HI_IDX_WORD:
        ofs = add_byte(base_word,
                       index_pair[spmd_pkg::IDX_HI_LSB +: spmd_pkg::BYTE_W]);
      spmd_pkg::SPMD_AM_LO_IDX_WORD:
        ofs = add_byte(base_word, index_pair[spmd_pkg::BYTE_W-1:0]);
      spmd_pkg::SPMD_AM_PAIR_WORD:
        ofs = add_word(base_word, index_pair);
      default: ofs = abs_offset;
    endcase
    // the segment value is taken as loaded; software sets it beforehand
    seg = prefix_pending ? extension_segment_reg : spmd_pkg::WINDOW_SEG;
    next_data_addr = data_addr;
    next_data_addr_valid = addr_req;
    next_data_addr_ext = data_addr_ext;
    if (addr_req)
    begin
      next_data_addr = {seg, ofs};
      next_data_addr_ext = prefix_pending;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_addr <= spmd_pkg::ADDR_RESET;
      data_addr_valid <= 1'b0;
      data_addr_ext <= 1'b0;
    end
    else
    begin
      data_addr <= next_data_addr;
      data_addr_valid <= next_data_addr_valid;
      data_addr_ext <= next_data_addr_ext;
    end
  end

  // ==========================================================
  // interrupt and dma acknowledge
  // held off from the prefix byte itself through the target's completion
  // the prefix byte is masked combinationally, so a request raised with it waits too
  // ack drops for a cycle between pulses so one held request is not taken twice
  always_comb
  begin
    hold_off = is_prefix || prefix_pending;
    next_irq_ack = irq_req && !hold_off && !irq_ack;
    next_dma_ack = dma_req && !hold_off && !dma_ack;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_ack <= 1'b0;
      dma_ack <= 1'b0;
    end
    else
    begin
      irq_ack <= next_irq_ack;
      dma_ack <= next_dma_ack;
    end
  end

  // ==========================================================
  // flags
  // status word lives in its own module so it keeps a single writer
  spmd_flag_update u_flags (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .flag_wr(flag_wr),
    .flag_code(flag_code),
    .result_flags(result_flags),
    .saved_flags(saved_flags),
    .flags(program_status_word)
  );

endmodule : spmd_decode

`default_nettype wire

// file: verif/spmd_decode_asserts.sv
// checker for the prefix decode block
// bound to spmd_decode from the bench top
`timescale 1ns/1ps
`default_nettype none
module spmd_decode_asserts (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic insn_done,
  input wire logic addr_req,
  input wire logic flag_wr,
  input wire logic [3:0] extension_segment_reg,
  input wire logic prefix_pending,
  input wire logic [19:0] data_addr,
  input wire logic data_addr_valid,
  input wire logic data_addr_ext,
  input wire logic irq_ack,
  input wire logic dma_ack,
  input wire logic [2:0] program_status_word
);
  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  a_prefix_arms: assert property (op_valid && op_byte == 8'h11 |=> prefix_pending)
    else $error("prefix did not arm");
  a_pend_hold: assert property (prefix_pending && !insn_done |=> prefix_pending)
    else $error("override dropped early");
  a_addr_valid: assert property (addr_req |=> data_addr_valid && data_addr_ext == $past(prefix_pending))
    else $error("address answer wrong");
  a_valid_cause: assert property (data_addr_valid |-> $past(addr_req))
    else $error("stray address strobe");
  a_seg_plain: assert property (addr_req && !prefix_pending |=> data_addr[19:16] == 4'hf)
    else $error("plain access left window");
  a_seg_ext: assert property (addr_req && prefix_pending |=> data_addr[19:16] == $past(extension_segment_reg))
    else $error("segment not applied");
  a_irq_held: assert property (prefix_pending || (op_valid && op_byte == 8'h11) |=> !irq_ack)
    else $error("irq taken while prefixed");
  a_dma_held: assert property (prefix_pending || (op_valid && op_byte == 8'h11) |=> !dma_ack)
    else $error("dma taken while prefixed");
  a_flag_keep: assert property (!flag_wr |=> $stable(program_status_word))
    else $error("flags moved without write");
endmodule : spmd_decode_asserts
`default_nettype wire

// file: verif/tb_segment_prefix_move_decode.sv
// self-checking bench for spmd_decode
// drives all inputs at the falling edge; no partner model
`timescale 1ns/1ps
`default_nettype none
module tb_segment_prefix_move_decode;
  logic ref_clk = 0, nrst = 0, op_valid = 0, insn_done = 0, addr_req = 0;
  logic irq_req = 0, dma_req = 0, flag_wr = 0;
  logic [7:0] op_byte = 8'h00, disp_byte = 8'h20;
  logic [2:0] addr_mode = 3'h0, result_flags = 3'h5, saved_flags = 3'h2, program_status_word;
  logic [15:0] abs_offset = 16'h5678, base_word = 16'hff00, second_pointer_pair = 16'hfff0;
  logic [15:0] third_pointer_pair = 16'h1234, index_pair = 16'hab12;
  logic [3:0] extension_segment_reg = 4'h3;
  logic [8:0] flag_code = 9'h000;
  logic [19:0] data_addr;
  logic prefix_pending, data_addr_valid, data_addr_ext, irq_ack, dma_ack;
  int n_errors = 0, num_checks = 0, cycles = 0;
  always #2 ref_clk = ~ref_clk;
  spmd_decode DUT (
    .ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid), .op_byte(op_byte),
    .insn_done(insn_done), .addr_req(addr_req), .addr_mode(addr_mode),
    .abs_offset(abs_offset), .disp_byte(disp_byte), .base_word(base_word),
    .second_pointer_pair(second_pointer_pair), .third_pointer_pair(third_pointer_pair),
    .index_pair(index_pair), .extension_segment_reg(extension_segment_reg),
    .irq_req(irq_req), .dma_req(dma_req), .flag_wr(flag_wr), .flag_code(flag_code),
    .result_flags(result_flags), .saved_flags(saved_flags),
    .prefix_pending(prefix_pending), .data_addr(data_addr), .data_addr_valid(data_addr_valid),
    .data_addr_ext(data_addr_ext), .irq_ack(irq_ack), .dma_ack(dma_ack),
    .program_status_word(program_status_word)
  );
  // ==========================================================
  // helpers
  task chk(input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  function logic [15:0] ofs(input logic [2:0] m);
    case (m)
      3'h0: ofs = abs_offset;
      3'h1: ofs = second_pointer_pair;
      3'h2: ofs = third_pointer_pair;
      3'h3: ofs = second_pointer_pair + 16'(disp_byte);
      3'h4: ofs = third_pointer_pair + 16'(disp_byte);
      3'h5: ofs = base_word + 16'(index_pair[15:8]);
      3'h6: ofs = base_word + 16'(index_pair[7:0]);
      default: ofs = base_word + index_pair;
    endcase
  endfunction : ofs
  // back to back requests, one per mode
  task all_modes(input logic [3:0] seg, input logic ext);
    addr_req = 1;
    for (int m = 0; m < 8; m++)
    begin
      addr_mode = 3'(m);
      @(negedge ref_clk);
      chk(20'(data_addr_valid), 20'h1);
      chk(data_addr, {seg, ofs(3'(m))});
      chk(20'(data_addr_ext), 20'(ext));
    end
    addr_req = 0;
  endtask : all_modes
  // ==========================================================
  // scenarios
  task t_prefix;
    extension_segment_reg = 4'h3;
    irq_req = 1;
    dma_req = 1;
    op_valid = 1;
    op_byte = 8'h11;
    @(negedge ref_clk);
    chk(20'({irq_ack, dma_ack}), 20'h0);
    op_valid = 0;
    insn_done = 1;
    @(negedge ref_clk);
    insn_done = 0;
    chk(20'(prefix_pending), 20'h1);
    op_valid = 1;
    op_byte = 8'h8b;
    @(negedge ref_clk);
    op_valid = 0;
    chk(20'({irq_ack, dma_ack}), 20'h0);
    all_modes(4'h3, 1'b1);
    chk(20'({irq_ack, dma_ack}), 20'h0);
    insn_done = 1;
    @(negedge ref_clk);
    insn_done = 0;
    chk(20'(prefix_pending), 20'h0);
    @(negedge ref_clk);
    chk(20'({irq_ack, dma_ack}), 20'h3);
    irq_req = 0;
    dma_req = 0;
  endtask : t_prefix
  task t_plain;
    op_valid = 1;
    op_byte = 8'hcf;
    @(negedge ref_clk);
    op_valid = 0;
    chk(20'(prefix_pending), 20'h0);
    all_modes(4'hf, 1'b0);
  endtask : t_plain
  // next prefix arrives with the target's completion
  task t_chain;
    op_valid = 1;
    op_byte = 8'h11;
    @(negedge ref_clk);
    op_byte = 8'h8b;
    @(negedge ref_clk);
    op_byte = 8'h11;
    insn_done = 1;
    @(negedge ref_clk);
    chk(20'(prefix_pending), 20'h1);
    op_byte = 8'hcf;
    addr_req = 1;
    @(negedge ref_clk);
    op_valid = 0;
    insn_done = 0;
    addr_req = 0;
    chk(20'(data_addr_ext), 20'h1);
    chk(20'(prefix_pending), 20'h0);
  endtask : t_chain
  task t_flags;
    logic [2:0] exp;
    exp = 3'h0;
    flag_wr = 1;
    for (int c = 0; c < 8; c++)
    begin
      flag_code = {3{3'(c)}};
      @(negedge ref_clk);
      case (c)
        1: exp = 3'h0;
        2: exp = 3'h7;
        3: exp = result_flags;
        4: exp = saved_flags;
        default: exp = exp;
      endcase
      chk(20'(program_status_word), 20'(exp));
    end
    flag_wr = 0;
    flag_code = 9'h049;
    @(negedge ref_clk);
    chk(20'(program_status_word), 20'(exp));
    flag_wr = 1;
    flag_code = {3'h2, 3'h0, 3'h1};
    @(negedge ref_clk);
    flag_wr = 0;
    chk(20'(program_status_word), 20'h6);
  endtask : t_flags
  task finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // ==========================================================
  // main sequence and hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (4) @(negedge ref_clk);
    chk(20'({prefix_pending, irq_ack, dma_ack, data_addr_valid, program_status_word}), 20'h0);
    nrst = 1;
    @(negedge ref_clk);
    t_prefix();
    t_plain();
    t_chain();
    t_flags();
    finish_test();
  end
endmodule : tb_segment_prefix_move_decode
bind spmd_decode spmd_decode_asserts u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid), .op_byte(op_byte),
  .insn_done(insn_done), .addr_req(addr_req), .flag_wr(flag_wr),
  .extension_segment_reg(extension_segment_reg), .prefix_pending(prefix_pending),
  .data_addr(data_addr), .data_addr_valid(data_addr_valid), .data_addr_ext(data_addr_ext),
  .irq_ack(irq_ack), .dma_ack(dma_ack), .program_status_word(program_status_word)
);
`default_nettype wire
